//--- inc/ccu_pkg.sv
// Purpose: Shared constants for the capture/compare unit.
// Assumes: AXI4-Lite register access with 32-bit data, two channels.
// Notes:   Offsets are byte addresses on the register bus.
package ccu_pkg;
	localparam int          NUM_CHAN        = 2;
	localparam int          ADDR_W          = 8;
	// Register offsets
	localparam logic [7:0]  OFF_CTRL_ONE    = 8'h00;
	localparam logic [7:0]  OFF_CTRL_TWO    = 8'h04;
	localparam logic [7:0]  OFF_VALUE_ONE   = 8'h08;
	localparam logic [7:0]  OFF_VALUE_TWO   = 8'h0C;
	localparam logic [7:0]  OFF_TIMER_SEL   = 8'h10;
	localparam logic [7:0]  OFF_FLAG        = 8'h14;
	localparam logic [7:0]  OFF_ENABLE      = 8'h18;
	localparam logic [7:0]  OFF_PORT        = 8'h1C;
	// Field positions
	localparam int          CTRL_MODE_LSB   = 0;
	localparam int          CTRL_DC_LSB     = 4;
	localparam int          FLAG_BASE_BIT   = 1;
	localparam int          SEL_CH_ONE_BIT  = 3;
	localparam int          SEL_CH_TWO_BIT  = 6;
	localparam int          PORT_LATCH_LSB  = 0;
	localparam int          PORT_DIR_LSB    = 8;
	// Reset values
	localparam logic [5:0]  CTRL_RESET      = 6'h00;
	localparam logic [15:0] VALUE_RESET     = 16'h0000;
	localparam logic [1:0]  DIR_RESET       = 2'h3;
	// Mode codes
	localparam logic [3:0]  MODE_OFF        = 4'h0;
	localparam logic [3:0]  MODE_TOGGLE     = 4'h2;
	localparam logic [3:0]  MODE_CAP_FALL   = 4'h4;
	localparam logic [3:0]  MODE_CAP_RISE   = 4'h5;
	localparam logic [3:0]  MODE_CAP_RISE4  = 4'h6;
	localparam logic [3:0]  MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0]  MODE_SET_HIGH   = 4'h8;
	localparam logic [3:0]  MODE_SET_LOW    = 4'h9;
	localparam logic [3:0]  MODE_SOFT_IRQ   = 4'hA;
	localparam logic [3:0]  MODE_SPECIAL    = 4'hB;
	// Prescaler terminal counts
	localparam logic [3:0]  PRESC_LAST4     = 4'h3;
	localparam logic [3:0]  PRESC_LAST16    = 4'hF;
	// Bus responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : ccu_pkg

//--- logic/ccu_pin_sync.sv
// Purpose: Synchronise channel pins and detect their edges.
// Assumes: Pins may change at any time relative to clk.
// Notes:   Edges are taken from the second and third stages only.
`timescale 1ns/10ps
module ccu_pin_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0] last;
	} ccu_sync_s;

	ccu_sync_s state_reg;
	ccu_sync_s state_next;

	initial begin
		if (WIDTH < 1) $error("ccu_pin_sync: WIDTH must be at least 1");
	end

	always_comb begin
		state_next        = state_reg;
		state_next.meta   = pin_in;
		state_next.stable = state_reg.meta;
		state_next.last   = state_reg.stable;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// One pulse per edge seen on the settled copy
	assign rise = state_reg.stable & ~state_reg.last;
	assign fall = ~state_reg.stable & state_reg.last;
endmodule : ccu_pin_sync

//--- logic/ccu_chan.sv
// Purpose: One capture/compare channel core: event qualify, prescale, match, output latch.
// Assumes: Timer count is already the selected time base.
// Notes:   Pulse outputs are combinational and last one cycle.
`timescale 1ns/10ps
module ccu_chan #(
	parameter int TW = 16
) (
	input  wire logic          clk,
	input  wire logic          sys_rst,
	input  wire logic [3:0]    mode,
	input  wire logic [TW-1:0] value,
	input  wire logic [TW-1:0] timer_count,
	input  wire logic          rise,
	input  wire logic          fall,
	output logic               capture_evt,
	output logic               flag_set,
	output logic               special_evt,
	output logic               cmp_latch
);
	typedef struct packed {
		logic [3:0] prescale;
		logic [3:0] prev_mode;
		logic       eq_prev;
		logic       latch;
	} ccu_chan_s;

	ccu_chan_s state_reg;
	ccu_chan_s state_next;
	logic      equal;
	logic      match;
	logic      cap_switch;

	initial begin
		if (TW < 1 || TW > 32) $error("ccu_chan: TW out of range");
	end

	function automatic logic is_cap(input logic [3:0] m);
		return m[3:2] == 2'b01;
	endfunction : is_cap

	function automatic logic is_cmp(input logic [3:0] m);
		return (m == ccu_pkg::MODE_TOGGLE) || (m[3:2] == 2'b10);
	endfunction : is_cmp

	always_comb begin
		state_next           = state_reg;
		state_next.prev_mode = mode;
		case (mode)
			ccu_pkg::MODE_CAP_FALL:   capture_evt = fall;
			ccu_pkg::MODE_CAP_RISE:   capture_evt = rise;
			ccu_pkg::MODE_CAP_RISE4:  capture_evt = rise && (state_reg.prescale >= ccu_pkg::PRESC_LAST4);
			ccu_pkg::MODE_CAP_RISE16: capture_evt = rise && (state_reg.prescale >= ccu_pkg::PRESC_LAST16);
			default:                  capture_evt = 1'b0;
		endcase
		// Counter survives a direct switch between capture modes
		if (!is_cap(mode)) begin
			state_next.prescale = 4'h0;
		end else if (rise && mode[1]) begin
			state_next.prescale = capture_evt ? 4'h0 : state_reg.prescale + 4'h1;
		end
		equal              = is_cmp(mode) && (value == timer_count);
		match              = equal && !state_reg.eq_prev;
		state_next.eq_prev = equal;
		if (mode == ccu_pkg::MODE_OFF) begin
			state_next.latch = 1'b0;
		end else if (mode != state_reg.prev_mode && mode == ccu_pkg::MODE_SET_HIGH) begin
			state_next.latch = 1'b0;
		end else if (mode != state_reg.prev_mode && mode == ccu_pkg::MODE_SET_LOW) begin
			state_next.latch = 1'b1;
		end else if (match) begin
			case (mode)
				ccu_pkg::MODE_SET_HIGH: state_next.latch = 1'b1;
				ccu_pkg::MODE_SET_LOW:  state_next.latch = 1'b0;
				ccu_pkg::MODE_TOGGLE:   state_next.latch = ~state_reg.latch;
				default:                state_next.latch = state_reg.latch;
			endcase
		end
		// Spurious flag on a direct prescaler change
		cap_switch  = is_cap(mode) && is_cap(state_reg.prev_mode) && (mode != state_reg.prev_mode);
		flag_set    = capture_evt || match || cap_switch;
		special_evt = match && (mode == ccu_pkg::MODE_SPECIAL);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign cmp_latch = state_next.latch;
endmodule : ccu_chan

//--- logic/ccu_top.sv
// Purpose: Two-channel capture/compare unit with AXI4-Lite registers.
// Assumes: Timer counts come from outside; timers are in timer or synchronised counter mode.
// Notes:   Special event resets are one-cycle pulses back to the timers.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Operation
// - A capture copies the selected 16-bit timer count into the channel value.
// - Capture event is falling, rising, every fourth or every sixteenth rising edge.
// - Every capture sets the channel flag; only software writes clear it.
// - A newer capture overwrites the previous value, no overrun protection.
// - Edge detector watches the pin, so port writes on output can capture.
// - Timer selection bits choose timer one or three per channel.
// - Mode changes may raise a spurious flag; software masks and clears it.
// - Prescaler counter clears whenever channel is off or not capturing.
// - Direct prescaler change keeps counter and may set the flag.
// - Compare mode checks channel value against selected timer for equality.
// - Match drives pin high, low, toggles, or leaves port latch.
// - Flag is set together with the pin action on every match.
// - Zero written to control forces the compare output latch low.
// - Software interrupt mode sets only the flag, pin untouched.
// - Channel two trigger resets timer and may start conversion; one resets only.
// - A trigger resetting a shared timer affects the other channel too.
// - Both channels in pulse-width mode share one period and update rate.
// - Capture codes 0100, 0101, 0110, 0111 as falling, rising, fourth, sixteenth.
// - Compare codes 0010 toggle, 1000 set high, 1001 set low, 1011 trigger.
// - Code 0000 disables the channel and resets its internal state.
module ccu_top #(
	parameter int TW = 16
) (
	input  wire logic                        clk,
	input  wire logic                        sys_rst,
	// AXI4-Lite slave
	input  wire logic [ccu_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ccu_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Time bases
	input  wire logic [TW-1:0]               timer_one_count,
	input  wire logic [TW-1:0]               timer_three_count,
	input  wire logic                        timer_two_period,
	output logic                             timer_one_reset,
	output logic                             timer_three_reset,
	output logic [1:0]                       pwm_period_tick,
	// Conversion trigger
	input  wire logic                        adc_enable,
	output logic                             adc_start,
	// Channel pins and interrupt requests
	input  wire logic [1:0]                  pin_in,
	output logic [1:0]                       pin_out,
	output logic [1:0]                       pin_oe_n,
	output logic [1:0]                       chan_irq_req
);
	localparam int NC = ccu_pkg::NUM_CHAN;

	typedef struct packed {
		logic [NC-1:0][5:0]    chan_control;
		logic [NC-1:0][TW-1:0] chan_value;
		logic [NC-1:0]         timer_sel;
		logic [NC-1:0]         chan_irq_flag;
		logic [NC-1:0]         chan_irq_enable;
		logic [NC-1:0]         port_latch;
		logic [NC-1:0]         port_direction;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
		logic [NC-1:0]         pin_out;
		logic [NC-1:0]         irq_req;
		logic                  t1_reset;
		logic                  t3_reset;
		logic                  adc_go;
		logic [NC-1:0]         pwm_tick;
	} ccu_top_s;

	ccu_top_s              state_reg;
	ccu_top_s              state_next;
	logic [NC-1:0]         rise;
	logic [NC-1:0]         fall;
	logic [NC-1:0]         capture_evt;
	logic [NC-1:0]         flag_set;
	logic [NC-1:0]         special_evt;
	logic [NC-1:0]         cmp_latch;
	logic [NC-1:0][TW-1:0] chan_timer;
	logic [NC-1:0][3:0]    chan_mode;
	logic                  wr_take;
	logic                  rd_take;
	logic                  wr_hit;
	logic                  rd_hit;
	logic [31:0]           rd_word;
	logic [31:0]           cur_word;
	logic [31:0]           new_word;

	initial begin
		if (TW != 16) $error("ccu_top: channel value is 16 bits wide");
		if (NC != 2) $error("ccu_top: exactly two channels are supported");
	end

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge_strb(input logic [31:0] old_w, input logic [31:0] new_w,
						   input logic [3:0] strb);
		logic [31:0] res;
		res = old_w;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) res[b*8 +: 8] = new_w[b*8 +: 8];
		end
		return res;
	endfunction : merge_strb

	function automatic logic is_cmp_pin(input logic [3:0] m);
		return (m == ccu_pkg::MODE_TOGGLE) || (m == ccu_pkg::MODE_SET_HIGH) ||
		       (m == ccu_pkg::MODE_SET_LOW) || (m == ccu_pkg::MODE_SPECIAL);
	endfunction : is_cmp_pin

	// Current contents of a mapped register
	function automatic logic [31:0] reg_word(input ccu_top_s s, input logic [7:0] a, output logic hit);
		logic [31:0] w;
		w   = 32'h0000_0000;
		hit = 1'b1;
		case (a)
			ccu_pkg::OFF_CTRL_ONE:  w[5:0]  = s.chan_control[0];
			ccu_pkg::OFF_CTRL_TWO:  w[5:0]  = s.chan_control[1];
			ccu_pkg::OFF_VALUE_ONE: w[15:0] = s.chan_value[0];
			ccu_pkg::OFF_VALUE_TWO: w[15:0] = s.chan_value[1];
			ccu_pkg::OFF_TIMER_SEL: begin
				w[ccu_pkg::SEL_CH_ONE_BIT] = s.timer_sel[0];
				w[ccu_pkg::SEL_CH_TWO_BIT] = s.timer_sel[1];
			end
			ccu_pkg::OFF_FLAG:      w[ccu_pkg::FLAG_BASE_BIT +: NC] = s.chan_irq_flag;
			ccu_pkg::OFF_ENABLE:    w[ccu_pkg::FLAG_BASE_BIT +: NC] = s.chan_irq_enable;
			ccu_pkg::OFF_PORT: begin
				w[ccu_pkg::PORT_LATCH_LSB +: NC] = s.port_latch;
				w[ccu_pkg::PORT_DIR_LSB +: NC]   = s.port_direction;
			end
			default:                hit = 1'b0;
		endcase
		return w;
	endfunction : reg_word

	ccu_pin_sync #(
		.WIDTH   (NC)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin_in  (pin_in),
		.rise    (rise),
		.fall    (fall)
	);

	for (genvar g = 0; g < NC; g++) begin : g_chan
		assign chan_mode[g]  = state_reg.chan_control[g][ccu_pkg::CTRL_MODE_LSB +: 4];
		assign chan_timer[g] = state_reg.timer_sel[g] ? timer_three_count : timer_one_count;

		ccu_chan #(
			.TW          (TW)
		) u_chan (
			.clk         (clk),
			.sys_rst     (sys_rst),
			.mode        (chan_mode[g]),
			.value       (state_reg.chan_value[g]),
			.timer_count (chan_timer[g]),
			.rise        (rise[g]),
			.fall        (fall[g]),
			.capture_evt (capture_evt[g]),
			.flag_set    (flag_set[g]),
			.special_evt (special_evt[g]),
			.cmp_latch   (cmp_latch[g])
		);
	end

	// Both write channels are taken together, one write outstanding
	assign wr_take = s_axi_awvalid && s_axi_wvalid && !state_reg.bvalid;
	assign rd_take = s_axi_arvalid && !state_reg.rvalid;

	always_comb begin
		state_next = state_reg;
		cur_word   = reg_word(state_reg, s_axi_awaddr, wr_hit);
		new_word   = merge_strb(cur_word, s_axi_wdata, s_axi_wstrb);
		rd_word    = reg_word(state_reg, s_axi_araddr, rd_hit);

		// Write response
		if (state_reg.bvalid && s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (wr_take) begin
			state_next.bvalid = 1'b1;
			state_next.bresp  = wr_hit ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
			case (s_axi_awaddr)
				ccu_pkg::OFF_CTRL_ONE:  state_next.chan_control[0] = new_word[5:0];
				ccu_pkg::OFF_CTRL_TWO:  state_next.chan_control[1] = new_word[5:0];
				ccu_pkg::OFF_VALUE_ONE: state_next.chan_value[0]   = new_word[15:0];
				ccu_pkg::OFF_VALUE_TWO: state_next.chan_value[1]   = new_word[15:0];
				ccu_pkg::OFF_TIMER_SEL: begin
					state_next.timer_sel[0] = new_word[ccu_pkg::SEL_CH_ONE_BIT];
					state_next.timer_sel[1] = new_word[ccu_pkg::SEL_CH_TWO_BIT];
				end
				ccu_pkg::OFF_FLAG:      state_next.chan_irq_flag   = new_word[ccu_pkg::FLAG_BASE_BIT +: NC];
				ccu_pkg::OFF_ENABLE:    state_next.chan_irq_enable = new_word[ccu_pkg::FLAG_BASE_BIT +: NC];
				ccu_pkg::OFF_PORT: begin
					state_next.port_latch     = new_word[ccu_pkg::PORT_LATCH_LSB +: NC];
					state_next.port_direction = new_word[ccu_pkg::PORT_DIR_LSB +: NC];
				end
				default: begin
				end
			endcase
		end

		// Read response
		if (state_reg.rvalid && s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (rd_take) begin
			state_next.rvalid = 1'b1;
			state_next.rdata  = rd_word;
			state_next.rresp  = rd_hit ? ccu_pkg::RESP_OKAY : ccu_pkg::RESP_SLVERR;
		end

		for (int c = 0; c < NC; c++) begin
			// Hardware capture beats a same-cycle software write
			if (capture_evt[c]) begin
				state_next.chan_value[c] = chan_timer[c];
			end
			// Hardware set beats a same-cycle software clear
			if (flag_set[c]) begin
				state_next.chan_irq_flag[c] = 1'b1;
			end
			// Compare latch drives the pin only in pin-driving compare modes
			if (is_cmp_pin(chan_mode[c])) begin
				state_next.pin_out[c] = cmp_latch[c];
			end else begin
				state_next.pin_out[c] = state_next.port_latch[c];
			end
			// Both channels tick from the single period source
			state_next.pwm_tick[c] = timer_two_period && (chan_mode[c][3:2] == 2'b11);
		end

		// Trigger resets whichever timer the channel uses, shared or not
		state_next.t1_reset = (special_evt[0] && !state_reg.timer_sel[0]) ||
				      (special_evt[1] && !state_reg.timer_sel[1]);
		state_next.t3_reset = (special_evt[0] && state_reg.timer_sel[0]) ||
				      (special_evt[1] && state_reg.timer_sel[1]);
		state_next.adc_go   = special_evt[1] && adc_enable;
		state_next.irq_req  = state_next.chan_irq_flag & state_next.chan_irq_enable;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg                 <= '0;
			state_reg.chan_control    <= {NC{ccu_pkg::CTRL_RESET}};
			state_reg.chan_value      <= {NC{ccu_pkg::VALUE_RESET}};
			state_reg.port_direction  <= ccu_pkg::DIR_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign s_axi_awready     = wr_take;
	assign s_axi_wready      = wr_take;
	assign s_axi_bvalid      = state_reg.bvalid;
	assign s_axi_bresp       = state_reg.bresp;
	assign s_axi_arready     = rd_take;
	assign s_axi_rvalid      = state_reg.rvalid;
	assign s_axi_rdata       = state_reg.rdata;
	assign s_axi_rresp       = state_reg.rresp;
	assign timer_one_reset   = state_reg.t1_reset;
	assign timer_three_reset = state_reg.t3_reset;
	assign adc_start         = state_reg.adc_go;
	assign pwm_period_tick   = state_reg.pwm_tick;
	assign pin_out           = state_reg.pin_out;
	// Direction bit set means input, so the driver is released
	assign pin_oe_n          = state_reg.port_direction;
	assign chan_irq_req      = state_reg.irq_req;
endmodule : ccu_top

//--- verification/ccu_checker.sv
// Purpose: Port-level assertions for the capture/compare unit.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to every ccu_top instance.
`timescale 1ns/10ps
module ccu_checker (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       timer_one_reset,
	input wire logic       timer_three_reset,
	input wire logic       timer_two_period,
	input wire logic [1:0] pwm_period_tick,
	input wire logic       adc_enable,
	input wire logic       adc_start,
	input wire logic [1:0] chan_irq_req
);
	logic [3:0] wr_age_reg;
	// Cycles since the last accepted register write, saturating
	always_ff @(posedge clk) begin
		if (sys_rst || (s_axi_awvalid && s_axi_awready))
			wr_age_reg <= 4'h0;
		else if (wr_age_reg != 4'hF)
			wr_age_reg <= wr_age_reg + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_flag_sw_only: assert property (($fell(chan_irq_req[0]) || $fell(chan_irq_req[1])) |-> wr_age_reg < 4'h4)
		else $error("interrupt request dropped with no bus write");
	a_adc_enabled: assert property (adc_start |-> $past(adc_enable))
		else $error("conversion start while converter disabled");
	a_adc_with_reset: assert property (adc_start |-> timer_one_reset || timer_three_reset)
		else $error("conversion start without timer reset");
	a_rst_one_pulse: assert property (timer_one_reset |=> !timer_one_reset)
		else $error("timer one reset repeated");
	a_rst_three_pulse: assert property (timer_three_reset |=> !timer_three_reset)
		else $error("timer three reset repeated");
	a_tick_cause: assert property (|pwm_period_tick |-> $past(timer_two_period))
		else $error("period tick without shared period event");
	a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response missing");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response missing");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	c_adc: cover property (adc_start);
	c_rst_one: cover property (timer_one_reset);
	c_irq_clear: cover property ($fell(chan_irq_req[1]));
endmodule : ccu_checker

bind ccu_top ccu_checker u_ccu_checker (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .timer_one_reset,
	.timer_three_reset, .timer_two_period, .pwm_period_tick, .adc_enable, .adc_start, .chan_irq_req);

//--- verification/ccu_pin_model.sv
// Purpose: External source or load on the two channel pins.
// Assumes: No pull resistors on the pins.
// Notes:   A pin nobody drives shows a pattern that changes every cycle.
`timescale 1ns/10ps
module ccu_pin_model (
	input  wire logic       clk,
	input  wire logic [1:0] ext_drive,
	input  wire logic [1:0] ext_level,
	input  wire logic [1:0] pin_out,
	input  wire logic [1:0] pin_oe_n,
	output logic      [1:0] pin_in
);
	logic [1:0] last_reg;
	always_ff @(posedge clk)
		last_reg <= pin_in;
	// Source drives only a pin set as input; an output pin reads back its own level
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ((ext_drive & ext_level) | (~ext_drive & ~last_reg)));
endmodule : ccu_pin_model

//--- verification/ccu_top_test.sv
// Purpose: Self-checking bench for the capture/compare unit.
// Assumes: Bench drives timers and pins; converter enabled throughout.
// Notes:   Channel two captures on timer three; compare uses one per channel.
`timescale 1ns/10ps
module ccu_top_test;
	localparam logic [3:0] CAP_M [4] = '{ccu_pkg::MODE_CAP_FALL, ccu_pkg::MODE_CAP_RISE, ccu_pkg::MODE_CAP_RISE4,
		ccu_pkg::MODE_CAP_RISE16};
	localparam logic [3:0] CMP_M [5] = '{ccu_pkg::MODE_TOGGLE, ccu_pkg::MODE_SET_HIGH, ccu_pkg::MODE_SET_LOW,
		ccu_pkg::MODE_SOFT_IRQ, ccu_pkg::MODE_SPECIAL};
	localparam logic [4:0] BEF = 5'h0C;
	localparam logic [4:0] AFT = 5'h0B;
	logic        clk = 1'b0, sys_rst = 1'b1, timer_two_period = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        timer_one_reset, timer_three_reset, adc_start;
	logic [1:0]  s_axi_bresp, s_axi_rresp, pwm_period_tick, pin_in, pin_out, pin_oe_n, chan_irq_req;
	logic [15:0] timer_one_count = 16'h1234, timer_three_count = 16'h0FFF;
	logic [1:0]  ext_drive = 2'h3, ext_level = 2'h0;
	int          failures = 0, tests_run = 0, n_rst = 0, n_adc = 0, n_pwm = 0;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		n_rst <= n_rst + int'(timer_one_reset) + 2 * int'(timer_three_reset);
		n_adc <= n_adc + int'(adc_start);
		n_pwm <= n_pwm + int'(pwm_period_tick[0]) + int'(pwm_period_tick[1]);
	end
	ccu_top DUT (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_one_count,
		.timer_three_count, .timer_two_period, .timer_one_reset, .timer_three_reset, .pwm_period_tick,
		.adc_enable(1'b1), .adc_start, .pin_in, .pin_out, .pin_oe_n, .chan_irq_req);
	ccu_pin_model u_pin (.clk, .ext_drive, .ext_level, .pin_out, .pin_oe_n, .pin_in);
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic hang;
		failures++;
		$display("BAD at %0t: bus answer never came", $time);
		test_done();
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = ccu_pkg::RESP_OKAY);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 50 && s_axi_awready !== 1'b1; n++) @(posedge clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++) @(posedge clk);
		if (s_axi_bvalid !== 1'b1)
			hang();
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = ccu_pkg::RESP_OKAY);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 50 && s_axi_arready !== 1'b1; n++) @(posedge clk);
		s_axi_arvalid <= 1'b0;
		for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++) @(posedge clk);
		if (s_axi_rvalid !== 1'b1)
			hang();
		chk(s_axi_rdata, exp);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rd
	// One pin pulse; the timer shows rv while high and fv while low
	task automatic pulse(input logic [15:0] rv, input logic [15:0] fv);
		timer_three_count <= rv;
		ext_level[1] <= 1'b1;
		repeat (6) @(posedge clk);
		timer_three_count <= fv;
		ext_level[1] <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : pulse
	task automatic set_tmr(input int c, input logic [15:0] v);
		if (c == 1)
			timer_three_count <= v;
		else
			timer_one_count <= v;
	endtask : set_tmr
	task automatic cmp(input int c, input int k);
		logic [7:0] ctl;
		int r0, a0;
		ctl = (c == 1) ? ccu_pkg::OFF_CTRL_TWO : ccu_pkg::OFF_CTRL_ONE;
		wr(ctl, 32'h0);
		wr(ctl + 8'h08, 32'h0000_0040);
		wr(ctl, {28'h0, CMP_M[k]});
		wr(ccu_pkg::OFF_FLAG, 32'h0);
		r0 = n_rst;
		a0 = n_adc;
		chk({31'h0, pin_out[c]}, {31'h0, BEF[k]});
		set_tmr(c, 16'h0040);
		repeat (4) @(posedge clk);
		set_tmr(c, 16'h0041);
		repeat (2) @(posedge clk);
		chk({31'h0, pin_out[c]}, {31'h0, AFT[k]});
		rd(ccu_pkg::OFF_FLAG, (c == 1) ? 32'h4 : 32'h2);
		chk({31'h0, chan_irq_req[c]}, 32'h1);
		chk(n_rst - r0, (k == 4) ? 32'(c + 1) : 32'h0);
		chk(n_adc - a0, (k == 4 && c == 1) ? 32'h1 : 32'h0);
		set_tmr(c, 16'h0FFF);
	endtask : cmp
	initial begin
		int i, j, n_ev;
		logic [15:0] rv, fv;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk({30'h0, pin_oe_n}, 32'h3);
		rd(ccu_pkg::OFF_PORT, 32'h0000_0300);
		rd(ccu_pkg::OFF_VALUE_TWO, 32'h0);
		rd(8'h20, 32'h0, ccu_pkg::RESP_SLVERR);
		wr(8'h24, 32'hFFFF_FFFF, ccu_pkg::RESP_SLVERR);
		$display("Register test done");
		wr(ccu_pkg::OFF_TIMER_SEL, 32'h0000_0040);
		wr(ccu_pkg::OFF_ENABLE, 32'h0000_0006);
		for (i = 0; i < 4; i++) begin
			n_ev = (i < 2) ? 1 : (i == 2) ? 4 : 16;
			rv = 16'h0A00 + 16'(i);
			fv = 16'h0B00 + 16'(i);
			wr(ccu_pkg::OFF_CTRL_TWO, 32'h0);
			wr(ccu_pkg::OFF_CTRL_TWO, {28'h0, CAP_M[i]});
			wr(ccu_pkg::OFF_FLAG, 32'h0);
			for (j = 1; j < n_ev; j++) pulse(16'h0100, 16'h0200);
			chk({31'h0, chan_irq_req[1]}, 32'h0);
			pulse(rv, fv);
			chk({31'h0, chan_irq_req[1]}, 32'h1);
			rd(ccu_pkg::OFF_VALUE_TWO, {16'h0, (i == 0) ? fv : rv});
			for (j = 0; j < n_ev; j++) pulse(rv + 16'h0100, fv + 16'h0100);
			rd(ccu_pkg::OFF_VALUE_TWO, {16'h0, (i == 0) ? fv : rv} + 32'h100);
		end
		wr(ccu_pkg::OFF_FLAG, 32'h0);
		wr(ccu_pkg::OFF_CTRL_TWO, {28'h0, ccu_pkg::MODE_CAP_RISE});
		rd(ccu_pkg::OFF_FLAG, 32'h0000_0004);
		$display("Capture test done");
		wr(ccu_pkg::OFF_PORT, 32'h0000_0003);
		ext_drive <= 2'h0;
		chk({30'h0, pin_oe_n}, 32'h0);
		for (i = 0; i < 2; i++)
			for (j = 0; j < 5; j++) cmp(i, j);
		wr(ccu_pkg::OFF_CTRL_TWO, 32'h0);
		wr(ccu_pkg::OFF_CTRL_TWO, {28'h0, ccu_pkg::MODE_CAP_RISE});
		wr(ccu_pkg::OFF_PORT, 32'h0);
		wr(ccu_pkg::OFF_FLAG, 32'h0);
		wr(ccu_pkg::OFF_PORT, 32'h0000_0002);
		repeat (6) @(posedge clk);
		rd(ccu_pkg::OFF_FLAG, 32'h0000_0004);
		$display("Compare test done");
		wr(ccu_pkg::OFF_CTRL_ONE, 32'h0000_000C);
		wr(ccu_pkg::OFF_CTRL_TWO, 32'h0000_000C);
		j = n_pwm;
		timer_two_period <= 1'b1;
		@(posedge clk);
		timer_two_period <= 1'b0;
		repeat (3) @(posedge clk);
		chk(n_pwm - j, 32'h2);
		$display("Shared period test done");
		test_done();
	end
endmodule : ccu_top_test
